// ---- common/stream_cipher_pkg.sv ----
`default_nettype none
package stream_cipher_pkg;
  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [12:0] KEY_WORD_0_OFF = 13'h0000;
  localparam logic [12:0] KEY_WORD_1_OFF = 13'h0004;
  localparam logic [12:0] KEY_WORD_2_OFF = 13'h0008;
  localparam logic [12:0] KEY_WORD_3_OFF = 13'h000C;
  localparam logic [12:0] OPERATION_CONTROL_OFF = 13'h0020;
  localparam logic [12:0] COMPLETION_FLAG_OFF = 13'h0024;
  localparam logic [12:0] INPUT_LOCATION_OFF = 13'h0028;
  localparam logic [12:0] OUTPUT_LOCATION_OFF = 13'h002C;
  localparam logic [12:0] BYTE_COUNT_OFF = 13'h0030;
  localparam logic [12:0] EVENT_STATUS_OFF = 13'h0034;
  localparam logic [12:0] EVENT_MASK_OFF = 13'h0038;
  // memory windows, selected by address bits 12:11
  localparam logic [1:0] WIN_REGS = 2'h0;
  localparam logic [1:0] WIN_MESSAGE = 2'h1;
  localparam logic [1:0] WIN_CONTEXT = 2'h2;
  localparam logic [12:0] REG_SPAN = 13'h0040;
  // ==========================================================
  // control fields
  localparam int CTRL_W = 12;
  localparam int PAGE_LSB = 0;
  localparam int PAGE_W = 3;
  localparam int RAW_KEYSTREAM_BIT = 8;
  localparam int MODE_LSB = 9;
  localparam int LONG_KEY_BIT = 11;
  localparam logic [1:0] MODE_EXPAND_CRYPT = 2'h0;
  localparam logic [1:0] MODE_CONTINUE = 2'h1;
  localparam logic [1:0] MODE_EXPAND_ONLY = 2'h2;
  // word index field of location registers
  localparam int LOC_LSB = 2;
  localparam int LOC_W = 4;
  localparam int COUNT_W = 12;
  // ==========================================================
  // memories and context layout
  localparam int MSG_BYTES = 2048;
  localparam int CTX_BYTES = 2048;
  localparam int MEM_AW = 11;
  localparam int PAGE_BYTES = 'h200;
  localparam logic [7:0] SAVED_I_OFF = 8'h00;
  localparam logic [7:0] SAVED_J_OFF = 8'h01;
  localparam logic [3:0] SHORT_KEY_BYTES = 4'h5;
  localparam logic [3:0] LONG_KEY_BYTES = 4'hF;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  // ==========================================================
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_FILL = 6'b000010,
    ST_MIX = 6'b000100,
    ST_LOAD = 6'b001000,
    ST_CRYPT = 6'b010000,
    ST_SAVE = 6'b100000
  } engine_state_e;
endpackage
`default_nettype wire

// ---- hdl/stream_cipher_engine.sv ----
// ==========================================================
// Overview of operation
// - 40- or 128-bit keys; expansion and encryption
// - control bit 8 writes raw key stream
// - context: 256-byte table plus i, j
// - context split in 0x200-byte pages
// - 2048-byte message and context memories
// - key word 0 bytes all used
// - 40-bit key uses only top byte of word 1
// - control write starts the engine; undefined mode 3 finishes at once
// - bits 10:9 pick expand/encrypt mode
// - bit 11 selects 128-bit key
// - bits 1:0 select context page; bit 2 ignored
// - input location word index in bits 5:2
// - output location word index
// - byte count in bits 11:0
// - status bit 0 reports finished
`timescale 1ns/1ps
`default_nettype none
module stream_cipher_engine (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [12:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic o_irq
);
  import stream_cipher_pkg::*;

  // ==========================================================
  // state
  typedef struct packed {
    engine_state_e st;
    logic [31:0] key0;
    logic [31:0] key1;
    logic [31:0] key2;
    logic [31:0] key3;
    logic [CTRL_W-1:0] ctrl;
    logic [LOC_W-1:0] src;
    logic [LOC_W-1:0] dst;
    logic [COUNT_W-1:0] total;
    logic done;
    logic ev_stat;
    logic ev_mask;
    logic [7:0] i;
    logic [7:0] j;
    logic [COUNT_W-1:0] cnt;
    logic [3:0] kidx;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
  } state_s;

  state_s q_r;
  state_s q_nxt;

  logic [7:0] msg_mem [MSG_BYTES];
  logic [7:0] ctx_mem [CTX_BYTES];

  // four byte write ports per memory
  logic [3:0] msg_we;
  logic [MEM_AW-1:0] msg_wa [4];
  logic [7:0] msg_wd [4];
  logic [3:0] ctx_we;
  logic [MEM_AW-1:0] ctx_wa [4];
  logic [7:0] ctx_wd [4];

  logic access;
  logic commit;
  logic [1:0] win;
  logic [MEM_AW-1:0] word_base;
  logic [31:0] rd_data;
  logic rd_hit;
  logic [1:0] page;
  logic [1:0] mode;
  logic [7:0] si;
  logic [7:0] sj;
  logic [7:0] jn;
  logic [7:0] in;
  logic [7:0] t;
  logic [7:0] ks;
  logic [MEM_AW-1:0] src_a;
  logic [MEM_AW-1:0] dst_a;
  logic [3:0] klast;

  // ==========================================================
  // helpers
  // key byte k of the 128-bit key, byte 0 in the top lane
  function automatic logic [7:0] key_byte(input logic [127:0] key,
                                          input logic [3:0] k);
    key_byte = key[8'(127 - 8 * int'(k)) -: 8];
  endfunction

  // table byte address inside a context page
  function automatic logic [MEM_AW-1:0] tab_addr(input logic [1:0] pg,
                                                 input logic hi,
                                                 input logic [7:0] b);
    tab_addr = {pg, hi, b};
  endfunction

  function automatic logic [31:0] mem_word(input logic [7:0] b0,
                                           input logic [7:0] b1,
                                           input logic [7:0] b2,
                                           input logic [7:0] b3);
    mem_word = {b0, b1, b2, b3};
  endfunction

  // ==========================================================
  // read decode
  always_comb begin
    win = i_paddr[12:11];
    word_base = {i_paddr[10:2], 2'b00};
    rd_data = RESET_WORD;
    rd_hit = 1'b1;
    // register holes and the top window answer with an error
    case (win)
      WIN_MESSAGE: begin
        rd_data = mem_word(msg_mem[word_base], msg_mem[word_base + 11'd1],
                           msg_mem[word_base + 11'd2],
                           msg_mem[word_base + 11'd3]);
      end
      WIN_CONTEXT: begin
        rd_data = mem_word(ctx_mem[word_base], ctx_mem[word_base + 11'd1],
                           ctx_mem[word_base + 11'd2],
                           ctx_mem[word_base + 11'd3]);
      end
      WIN_REGS: begin
        case ({i_paddr[12:2], 2'b00})
          KEY_WORD_0_OFF: rd_data = q_r.key0;
          KEY_WORD_1_OFF: rd_data = q_r.key1;
          KEY_WORD_2_OFF: rd_data = q_r.key2;
          KEY_WORD_3_OFF: rd_data = q_r.key3;
          OPERATION_CONTROL_OFF: rd_data = {20'h00000, q_r.ctrl};
          COMPLETION_FLAG_OFF: rd_data = {31'h0, q_r.done};
          INPUT_LOCATION_OFF: rd_data = {26'h0, q_r.src, 2'b00};
          OUTPUT_LOCATION_OFF: rd_data = {26'h0, q_r.dst, 2'b00};
          BYTE_COUNT_OFF: rd_data = {20'h00000, q_r.total};
          EVENT_STATUS_OFF: rd_data = {31'h0, q_r.ev_stat};
          EVENT_MASK_OFF: rd_data = {31'h0, q_r.ev_mask};
          default: rd_hit = 1'b0;
        endcase
      end
      default: rd_hit = 1'b0;
    endcase
  end

  // ==========================================================
  // next state
  always_comb begin
    q_nxt = q_r;
    msg_we = 4'h0;
    ctx_we = 4'h0;
    for (int b = 0; b < 4; b++) begin
      msg_wa[b] = '0;
      msg_wd[b] = 8'h00;
      ctx_wa[b] = '0;
      ctx_wd[b] = 8'h00;
    end
    // only four 0x200 pages fit the memory, so page bit 2 is ignored
    page = q_r.ctrl[PAGE_LSB +: 2];
    mode = q_r.ctrl[MODE_LSB +: 2];
    klast = q_r.ctrl[LONG_KEY_BIT] ? LONG_KEY_BYTES
                                   : SHORT_KEY_BYTES - 4'h1;
    src_a = 11'({q_r.src, 2'b00}) + 11'(q_r.cnt);
    dst_a = 11'({q_r.dst, 2'b00}) + 11'(q_r.cnt);
    in = q_r.i + 8'h01;
    si = 8'h00;
    sj = 8'h00;
    jn = 8'h00;
    t = 8'h00;
    ks = 8'h00;
    access = i_psel & i_penable & ~q_r.pready;
    commit = i_psel & i_penable & q_r.pready;

    // bus answer: one wait state, data registered
    q_nxt.pready = access;
    q_nxt.pslverr = access & ~rd_hit;
    q_nxt.prdata = (access & ~i_pwrite) ? rd_data : RESET_WORD;

    // event status cleared by its own read
    if (commit && !i_pwrite && win == WIN_REGS &&
        {i_paddr[12:2], 2'b00} == EVENT_STATUS_OFF) begin
      q_nxt.ev_stat = 1'b0;
    end

    // engine
    case (q_r.st)
      ST_IDLE: begin
        // holds until a control write
      end
      ST_FILL: begin
        ctx_we[0] = 1'b1;
        ctx_wa[0] = tab_addr(page, 1'b0, q_r.cnt[7:0]);
        ctx_wd[0] = q_r.cnt[7:0];
        q_nxt.cnt = q_r.cnt + 12'h001;
        if (q_r.cnt[7:0] == 8'hFF) begin
          q_nxt.st = ST_MIX;
          q_nxt.cnt = '0;
          q_nxt.kidx = 4'h0;
          q_nxt.j = 8'h00;
        end
      end
      ST_MIX: begin
        // the swap lands at the edge, in time for the next step
        si = ctx_mem[tab_addr(page, 1'b0, q_r.cnt[7:0])];
        jn = q_r.j + si + key_byte({q_r.key0, q_r.key1, q_r.key2,
                                    q_r.key3}, q_r.kidx);
        sj = ctx_mem[tab_addr(page, 1'b0, jn)];
        ctx_we[1:0] = 2'b11;
        ctx_wa[0] = tab_addr(page, 1'b0, q_r.cnt[7:0]);
        ctx_wd[0] = sj;
        ctx_wa[1] = tab_addr(page, 1'b0, jn);
        ctx_wd[1] = si;
        q_nxt.j = jn;
        q_nxt.cnt = q_r.cnt + 12'h001;
        q_nxt.kidx = (q_r.kidx == klast) ? 4'h0 : q_r.kidx + 4'h1;
        if (q_r.cnt[7:0] == 8'hFF) begin
          q_nxt.cnt = '0;
          q_nxt.i = 8'h00;
          q_nxt.j = 8'h00;
          if (mode == MODE_EXPAND_ONLY || q_r.total == '0) begin
            q_nxt.st = ST_SAVE;
          end else begin
            q_nxt.st = ST_CRYPT;
          end
        end
      end
      ST_LOAD: begin
        q_nxt.i = ctx_mem[tab_addr(page, 1'b1, SAVED_I_OFF)];
        q_nxt.j = ctx_mem[tab_addr(page, 1'b1, SAVED_J_OFF)];
        q_nxt.cnt = '0;
        q_nxt.st = (q_r.total == '0) ? ST_SAVE : ST_CRYPT;
      end
      ST_CRYPT: begin
        si = ctx_mem[tab_addr(page, 1'b0, in)];
        jn = q_r.j + si;
        sj = ctx_mem[tab_addr(page, 1'b0, jn)];
        t = si + sj;
        // the table read must see this cycle's swap
        if (t == in) begin
          ks = sj;
        end else if (t == jn) begin
          ks = si;
        end else begin
          ks = ctx_mem[tab_addr(page, 1'b0, t)];
        end
        ctx_we[1:0] = 2'b11;
        ctx_wa[0] = tab_addr(page, 1'b0, in);
        ctx_wd[0] = sj;
        ctx_wa[1] = tab_addr(page, 1'b0, jn);
        ctx_wd[1] = si;
        msg_we[0] = 1'b1;
        msg_wa[0] = dst_a;
        msg_wd[0] = q_r.ctrl[RAW_KEYSTREAM_BIT] ? ks
                                              : ks ^ msg_mem[src_a];
        q_nxt.i = in;
        q_nxt.j = jn;
        q_nxt.cnt = q_r.cnt + 12'h001;
        if (q_r.cnt == q_r.total - 12'h001) begin
          q_nxt.st = ST_SAVE;
        end
      end
      ST_SAVE: begin
        ctx_we[3:2] = 2'b11;
        ctx_wa[2] = tab_addr(page, 1'b1, SAVED_I_OFF);
        ctx_wd[2] = q_r.i;
        ctx_wa[3] = tab_addr(page, 1'b1, SAVED_J_OFF);
        ctx_wd[3] = q_r.j;
        q_nxt.done = 1'b1;
        q_nxt.ev_stat = 1'b1;
        q_nxt.st = ST_IDLE;
      end
      default: begin
        q_nxt.st = ST_IDLE;
      end
    endcase

    // bus writes come last, so they override the engine's ports;
    // software must leave a running operation alone, and a control
    // write restarts the engine, or stops it at once for the undefined mode
    if (commit && i_pwrite) begin
      case (win)
        WIN_MESSAGE: begin
          for (int b = 0; b < 4; b++) begin
            msg_we[b] = 1'b1;
            msg_wa[b] = word_base + 11'(b);
            msg_wd[b] = i_pwdata[8'(31 - 8 * b) -: 8];
          end
        end
        WIN_CONTEXT: begin
          for (int b = 0; b < 4; b++) begin
            ctx_we[b] = 1'b1;
            ctx_wa[b] = word_base + 11'(b);
            ctx_wd[b] = i_pwdata[8'(31 - 8 * b) -: 8];
          end
        end
        WIN_REGS: begin
          case ({i_paddr[12:2], 2'b00})
            KEY_WORD_0_OFF: q_nxt.key0 = i_pwdata;
            KEY_WORD_1_OFF: q_nxt.key1 = i_pwdata;
            KEY_WORD_2_OFF: q_nxt.key2 = i_pwdata;
            KEY_WORD_3_OFF: q_nxt.key3 = i_pwdata;
            OPERATION_CONTROL_OFF: begin
              q_nxt.ctrl = i_pwdata[CTRL_W-1:0];
              q_nxt.done = 1'b0;
              q_nxt.cnt = '0;
              case (i_pwdata[MODE_LSB +: 2])
                MODE_EXPAND_CRYPT: q_nxt.st = ST_FILL;
                MODE_EXPAND_ONLY: q_nxt.st = ST_FILL;
                MODE_CONTINUE: q_nxt.st = ST_LOAD;
                default: begin
                  // undefined mode: finish at once, touch nothing
                  q_nxt.st = ST_IDLE;
                  q_nxt.done = 1'b1;
                  q_nxt.ev_stat = 1'b1;
                end
              endcase
            end
            INPUT_LOCATION_OFF: q_nxt.src = i_pwdata[LOC_LSB +: LOC_W];
            OUTPUT_LOCATION_OFF: q_nxt.dst = i_pwdata[LOC_LSB +: LOC_W];
            BYTE_COUNT_OFF: q_nxt.total = i_pwdata[COUNT_W-1:0];
            EVENT_MASK_OFF: q_nxt.ev_mask = i_pwdata[0];
            default: begin
            end
          endcase
        end
        default: begin
        end
      endcase
    end

    q_nxt.irq = q_nxt.ev_stat & q_nxt.ev_mask;
  end

  // ==========================================================
  // registers
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      q_r <= '{st: ST_IDLE, default: '0};
    end else begin
      q_r <= q_nxt;
    end
  end

  // memories carry no reset; contents undefined until written
  // four write ports per memory keep a table swap to one cycle
  always_ff @(posedge i_clk) begin
    for (int b = 0; b < 4; b++) begin
      if (msg_we[b]) begin
        msg_mem[msg_wa[b]] <= msg_wd[b];
      end
      if (ctx_we[b]) begin
        ctx_mem[ctx_wa[b]] <= ctx_wd[b];
      end
    end
  end

  assign o_prdata = q_r.prdata;
  assign o_pready = q_r.pready;
  assign o_pslverr = q_r.pslverr;
  assign o_irq = q_r.irq;
endmodule
`default_nettype wire

// ---- tb/stream_cipher_engine_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module stream_cipher_engine_props (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [12:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic o_irq
);
  logic unmapped;
  logic rd_ans;
  // top window and register holes answer with an error
  assign unmapped = (i_paddr[12:11] == 2'h3) ||
    (i_paddr[12:11] == 2'h0 && (i_paddr[10:6] != 5'h00 ||
    i_paddr[5:4] == 2'h1 || i_paddr[5:2] == 4'hF));
  assign rd_ans = o_pready && !i_pwrite;
  // ==========================================================
  // bus answer
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_reset_n);
  sequence s_access;
    i_psel && i_penable && !o_pready;
  endsequence
  sequence s_answer;
    o_pready ##1 !o_pready;
  endsequence
  chk_ready_wait: assert property (s_access |=> s_answer)
    else $error("answer not one cycle after access");
  chk_ready_cause: assert property (
    o_pready |-> $past(i_psel && i_penable))
    else $error("answer without request");
  chk_err_alone: assert property (o_pslverr |-> o_pready)
    else $error("error outside answer");
  chk_err_map: assert property (
    o_pready && i_paddr[1:0] == 2'h0 |-> o_pslverr == unmapped)
    else $error("error flag does not match map");
  chk_rdata_idle: assert property (!rd_ans |-> o_prdata == 32'h0)
    else $error("read data outside read answer");
  // ==========================================================
  // reserved fields and interrupt
  chk_loc_fields: assert property (rd_ans &&
    (i_paddr == 13'h0028 || i_paddr == 13'h002C) |->
    o_prdata[31:6] == 26'h0 && o_prdata[1:0] == 2'h0)
    else $error("location reserved bits set");
  chk_len_fields: assert property (rd_ans && i_paddr == 13'h0030 |->
    o_prdata[31:12] == 20'h0)
    else $error("count reserved bits set");
  chk_irq_masked: assert property (o_pready && i_pwrite &&
    i_paddr == 13'h0038 && !i_pwdata[0] |-> ##[1:2] !o_irq)
    else $error("interrupt stays after mask cleared");
endmodule
bind stream_cipher_engine stream_cipher_engine_props u_props (
  .i_clk(i_clk),
  .i_reset_n(i_reset_n),
  .i_psel(i_psel),
  .i_penable(i_penable),
  .i_pwrite(i_pwrite),
  .i_paddr(i_paddr),
  .i_pwdata(i_pwdata),
  .o_prdata(o_prdata),
  .o_pready(o_pready),
  .o_pslverr(o_pslverr),
  .o_irq(o_irq)
);
`default_nettype wire

// ---- tb/stream_cipher_engine_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module stream_cipher_engine_tb;
  import stream_cipher_pkg::*;
  logic i_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic i_psel = 1'b0;
  logic i_penable = 1'b0;
  logic i_pwrite = 1'b0;
  logic [12:0] i_paddr = 13'h0;
  logic [31:0] i_pwdata = 32'h0;
  logic [31:0] o_prdata;
  logic o_pready;
  logic o_pslverr;
  logic o_irq;
  logic [31:0] q;
  logic e;
  logic [31:0] kw [4];
  logic [31:0] src [2] = '{32'hA0A1A2A3, 32'h5B6C7D8E};
  logic [7:0] s [256];
  logic [7:0] si;
  logic [7:0] sj;
  int miscompares = 0;
  int n_compared = 0;
  int cyc = 0;
  always #10 i_clk = ~i_clk;
  stream_cipher_engine dut (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_psel(i_psel),
    .i_penable(i_penable),
    .i_pwrite(i_pwrite),
    .i_paddr(i_paddr),
    .i_pwdata(i_pwdata),
    .o_prdata(o_prdata),
    .o_pready(o_pready),
    .o_pslverr(o_pslverr),
    .o_irq(o_irq)
  );
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task stop_test();
    $display("compared %0d, mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ==========================================================
  // bus access
  task apb(input logic w, input logic [12:0] a, input logic [31:0] d);
    int n;
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    n = 0;
    while (o_pready !== 1'b1) begin
      @(posedge i_clk);
      n++;
    end
    chk(32'(n), 32'h2);
    q = o_prdata;
    e = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask
  task wr(input logic [12:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rd(input logic [12:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  // ==========================================================
  // reference cipher state
  task ksa(input int n);
    logic [7:0] t;
    for (int k = 0; k < 256; k++) s[k] = 8'(k);
    sj = 8'h0;
    for (int k = 0; k < 256; k++) begin
      sj = sj + s[k] + kw[(k % n) / 4][31 - 8 * ((k % n) % 4) -: 8];
      t = s[k];
      s[k] = s[sj];
      s[sj] = t;
    end
    si = 8'h0;
    sj = 8'h0;
  endtask
  task ks(output logic [7:0] z);
    logic [7:0] t;
    si = si + 8'h1;
    sj = sj + s[si];
    t = s[si];
    s[si] = s[sj];
    s[sj] = t;
    z = s[8'(s[si] + s[sj])];
  endtask
  // output words are cleared first so untouched bytes read zero
  task run(input logic [11:0] c, input int nbytes);
    logic [31:0] x;
    logic [7:0] z;
    int nb;
    wr(13'h0820, 32'h0);
    wr(13'h0824, 32'h0);
    wr(BYTE_COUNT_OFF, 32'(nbytes));
    wr(OPERATION_CONTROL_OFF, {20'h0, c});
    rd(COMPLETION_FLAG_OFF);
    if (c[10:9] != 2'h3) chk({31'h0, q[0]}, 32'h0);
    for (int k = 0; k < 400 && q[0] !== 1'b1; k++) rd(COMPLETION_FLAG_OFF);
    chk({31'h0, q[0]}, 32'h1);
    nb = (c[10:9] < 2'h2) ? nbytes : 0;
    for (int w = 0; w < 2; w++) begin
      rd(13'h0820 + 13'(4 * w));
      for (int b = 0; b < 4; b++) begin
        x[31 - 8 * b -: 8] = 8'h0;
        if (4 * w + b < nb) begin
          ks(z);
          x[31 - 8 * b -: 8] = c[8] ? z : (src[w][31 - 8 * b -: 8] ^ z);
        end
      end
      chk(q, x);
    end
  endtask
  task ctxchk(input logic [1:0] p);
    rd({2'h2, p, 9'h000});
    chk(q, {s[0], s[1], s[2], s[3]});
    rd({2'h2, p, 9'h100});
    chk({16'h0, q[31:16]}, {16'h0, si, sj});
  endtask
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      stop_test();
    end
  end
  initial begin
    repeat (3) @(posedge i_clk);
    i_reset_n <= 1'b1;
    for (int k = 0; k < 13; k++) begin
      if (k < 4 || k > 7) begin
        rd(13'(4 * k));
        chk(q, 32'h0);
      end
    end
    rd(13'h0010);
    chk({31'h0, e}, 32'h1);
    wr(13'h003C, 32'hFFFFFFFF);
    chk({31'h0, e}, 32'h1);
    wr(INPUT_LOCATION_OFF, 32'hFFFFFFFF);
    rd(INPUT_LOCATION_OFF);
    chk(q, 32'h3C);
    wr(OUTPUT_LOCATION_OFF, 32'hFFFFFFFF);
    rd(OUTPUT_LOCATION_OFF);
    chk(q, 32'h3C);
    wr(BYTE_COUNT_OFF, 32'hFFFFFFFF);
    rd(BYTE_COUNT_OFF);
    chk(q, 32'hFFF);
    $display("test register map done");
    wr(INPUT_LOCATION_OFF, 32'h4);
    wr(OUTPUT_LOCATION_OFF, 32'h20);
    wr(13'h0804, src[0]);
    wr(13'h0808, src[1]);
    kw = '{32'h01020304, 32'h05060708, 32'h090A0B0C, 32'h0D0E0F10};
    for (int k = 0; k < 4; k++) begin
      wr(13'(4 * k), kw[k]);
      rd(13'(4 * k));
      chk(q, kw[k]);
    end
    wr(EVENT_MASK_OFF, 32'h1);
    ksa(16);
    run(12'h801, 7);
    chk({31'h0, o_irq}, 32'h1);
    ctxchk(2'h1);
    rd(EVENT_STATUS_OFF);
    chk({31'h0, q[0]}, 32'h1);
    repeat (2) @(posedge i_clk);
    chk({31'h0, o_irq}, 32'h0);
    run(12'hB01, 8);
    ctxchk(2'h1);
    $display("test long key and resume done");
    ksa(5);
    run(12'h402, 5);
    ctxchk(2'h2);
    run(12'h603, 4);
    wr(EVENT_MASK_OFF, 32'h0);
    repeat (2) @(posedge i_clk);
    chk({31'h0, o_irq}, 32'h0);
    $display("test short key and modes done");
    stop_test();
  end
endmodule
`default_nettype wire
